// File: src/pcg_pkg.sv
package pcg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_SYS_SRC = 16'h5060;
  localparam logic [15:0] IDX_NF = 16'h5062;
  localparam logic [15:0] IDX_LCD = 16'h5063;
  localparam logic [15:0] IDX_OUT = 16'h5064;
  localparam logic [15:0] IDX_TMR = 16'h5065;

  localparam logic [31:0] ADDR_SYS_SRC = {14'h0000, IDX_SYS_SRC, 2'h0};
  localparam logic [31:0] ADDR_NF = {14'h0000, IDX_NF, 2'h0};
  localparam logic [31:0] ADDR_LCD = {14'h0000, IDX_LCD, 2'h0};
  localparam logic [31:0] ADDR_OUT = {14'h0000, IDX_OUT, 2'h0};
  localparam logic [31:0] ADDR_TMR = {14'h0000, IDX_TMR, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SYS_SRC_BIT = 0;
  localparam int NF_NMI_BIT = 0;
  localparam int NF_RST_BIT = 1;
  localparam int LCD_EN_BIT = 0;
  localparam int LCD_SRC_BIT = 1;
  localparam int LCD_DIV_LSB = 2;
  localparam int OUT_SUB_EN_BIT = 0;
  localparam int OUT_MAIN_EN_BIT = 1;
  localparam int OUT_DIV_LSB = 2;
  localparam int TMR_EN_BIT = 0;
  localparam int TMR_DIV_LSB = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and writable bits
  localparam logic [7:0] SYS_SRC_RESET = 8'h00;
  localparam logic [7:0] NF_RESET = 8'h02;
  localparam logic [7:0] LCD_RESET = 8'h02;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] TMR_RESET = 8'h00;
  localparam logic [7:0] SYS_SRC_MASK = 8'h01;
  localparam logic [7:0] NF_MASK = 8'h03;
  localparam logic [7:0] LCD_MASK = 8'h1F;
  localparam logic [7:0] OUT_MASK = 8'h0F;
  localparam logic [7:0] TMR_MASK = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // Divider codes and counts
  localparam logic [3:0] LCD_DIV_BASE_BIT = 4'h4;
  localparam logic [2:0] LCD_DIV_MAX = 3'h4;
  localparam logic [2:0] TMR_DIV_MAX = 3'h5;
  localparam logic [1:0] OUT_DIV_MAX = 2'h2;
  localparam int MAIN_CNT_W = 9;
  localparam int SUB_CNT_W = 5;
  localparam int NF_PRESCALE = 8;
  localparam int NF_SAMPLES = 2;
  localparam int NF_MIN_SYS_CYCLES = NF_PRESCALE * NF_SAMPLES;
  localparam logic [2:0] NF_CNT_LAST = 3'(NF_PRESCALE - 1);

endpackage

// File: src/pcg_noise_filter.sv
`timescale 1ns/1ps
module pcg_noise_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_tick,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  import pcg_pkg::*;

  logic smp_q, smp_d;
  logic filt_q, filt_d;

  // Level accepted only once two filter-clock samples agree
  always_comb begin
    smp_d = smp_q;
    filt_d = filt_q;
    if (sample_tick) begin
      smp_d = din;
      if (smp_q == din) begin
        filt_d = din;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp_q <= 1'b0;
      filt_q <= 1'b0;
    end else begin
      smp_q <= smp_d;
      filt_q <= filt_d;
    end
  end

  assign dout = enable ? filt_q : din;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  filt_accept_a: assert property (sample_tick && smp_q == din |=> filt_q == $past(din))
    else $error("filter did not accept a stable level");
  filt_hold_a: assert property ($changed(filt_q) |-> $past(sample_tick) && $past(smp_q) == filt_q)
    else $error("filter output changed without two agreeing samples");
  filt_bypass_a: assert property (!enable |-> dout == din)
    else $error("disabled filter does not bypass");
  filt_rise_c: cover property (enable && $rose(dout));

endmodule

// File: src/pcg_top.sv
`timescale 1ns/1ps
// Overview of operation
// - LCD source select bit D1 picks sub oscillator when 1 (reset) else main.
// - Sub oscillator source passes to LCD undivided; divider code ignored.
// - Main oscillator source divided by 32..512 per field D[4:2], reset 0.
// - LCD clock enable D0 resets 0 blocking clock; 1 delivers it.
// - Timer divider D[3:1] divides sub clock by 1..32; reserved codes exist.
// - Timer clock enable D0 resets 0 blocking; 1 delivers divided clock.
// - Main clock output divider D[3:2] gives 1, 1/2, 1/4; reset 0.
// - Main output enable D1 drives divided main clock, 0 disables it.
// - Output enables act unsynchronised to the clock; glitches may appear.
// - Sub output enable D0 drives undivided sub clock, 0 disables it.
// - Separate reset and interrupt filters; D1 reset, D0 interrupt; 0 bypasses.
// - Filters sample at system clock/8; need 16 system cycles to pass.
// - Watchdog request feeds interrupt filter; outputs feed core reset, interrupt.
// - System source bit D0 selects sub when 1, main when 0; clocks filters.
// - Reset filter enable reads 1 after reset.
// - Interrupt filter enable reads 0 after reset.
module pcg_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MAIN_OSC_CLK,
  input wire logic SUB_OSC_CLK,
  input wire logic RESET_REQ_N,
  input wire logic WDT_NMI_REQ,
  output logic LCD_CLOCK,
  output logic TIMER_CLOCK,
  output logic MAIN_CLK_OUT,
  output logic SUB_CLK_OUT,
  output logic CORE_RESET_N,
  output logic CORE_NMI
);
  import pcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage 0 only feeds stage 1
  logic [1:0] main_sync_q, sub_sync_q, rst_sync_q, nmi_sync_q;
  logic main_prev_q, sub_prev_q;
  logic main_lvl, sub_lvl, main_rise, sub_rise;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      main_sync_q <= 2'h0;
      sub_sync_q <= 2'h0;
      rst_sync_q <= 2'h3;
      nmi_sync_q <= 2'h0;
      main_prev_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else begin
      main_sync_q <= {main_sync_q[0], MAIN_OSC_CLK};
      sub_sync_q <= {sub_sync_q[0], SUB_OSC_CLK};
      rst_sync_q <= {rst_sync_q[0], RESET_REQ_N};
      nmi_sync_q <= {nmi_sync_q[0], WDT_NMI_REQ};
      main_prev_q <= main_sync_q[1];
      sub_prev_q <= sub_sync_q[1];
    end
  end

  assign main_lvl = main_sync_q[1];
  assign sub_lvl = sub_sync_q[1];
  assign main_rise = main_sync_q[1] & ~main_prev_q;
  assign sub_rise = sub_sync_q[1] & ~sub_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] src_q, src_d, nf_q, nf_d, lcd_q, lcd_d, out_q, out_d, tmr_q, tmr_d;
  logic [31:0] prdata_q, prdata_d;
  logic wr_acc, hit;

  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign hit = (PADDR == ADDR_SYS_SRC) || (PADDR == ADDR_NF) || (PADDR == ADDR_LCD) ||
               (PADDR == ADDR_OUT) || (PADDR == ADDR_TMR);

  always_comb begin
    src_d = src_q;
    nf_d = nf_q;
    lcd_d = lcd_q;
    out_d = out_q;
    tmr_d = tmr_q;
    prdata_d = prdata_q;
    if (wr_acc) begin
      unique case (PADDR)
        ADDR_SYS_SRC: src_d = PWDATA[7:0] & SYS_SRC_MASK;
        ADDR_NF: nf_d = PWDATA[7:0] & NF_MASK;
        ADDR_LCD: lcd_d = PWDATA[7:0] & LCD_MASK;
        ADDR_OUT: out_d = PWDATA[7:0] & OUT_MASK;
        ADDR_TMR: tmr_d = PWDATA[7:0] & TMR_MASK;
        default: ;
      endcase
    end
    // Read data latched in the setup cycle so the access phase needs no wait
    if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        ADDR_SYS_SRC: prdata_d = {24'h000000, src_q};
        ADDR_NF: prdata_d = {24'h000000, nf_q};
        ADDR_LCD: prdata_d = {24'h000000, lcd_q};
        ADDR_OUT: prdata_d = {24'h000000, out_q};
        ADDR_TMR: prdata_d = {24'h000000, tmr_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      src_q <= SYS_SRC_RESET;
      nf_q <= NF_RESET;
      lcd_q <= LCD_RESET;
      out_q <= OUT_RESET;
      tmr_q <= TMR_RESET;
      prdata_q <= 32'h00000000;
    end else begin
      src_q <= src_d;
      nf_q <= nf_d;
      lcd_q <= lcd_d;
      out_q <= out_d;
      tmr_q <= tmr_d;
      prdata_q <= prdata_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  logic sys_sub_sel, lcd_en, lcd_src_sub, tmr_en, mout_en, sout_en;
  logic [2:0] lcd_div, tmr_div;
  logic [1:0] out_div;

  assign sys_sub_sel = src_q[SYS_SRC_BIT];
  assign lcd_en = lcd_q[LCD_EN_BIT];
  assign lcd_src_sub = lcd_q[LCD_SRC_BIT];
  assign lcd_div = lcd_q[LCD_DIV_LSB +: 3];
  assign tmr_en = tmr_q[TMR_EN_BIT];
  assign tmr_div = tmr_q[TMR_DIV_LSB +: 3];
  assign mout_en = out_q[OUT_MAIN_EN_BIT];
  assign sout_en = out_q[OUT_SUB_EN_BIT];
  assign out_div = out_q[OUT_DIV_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Edge counters; bit k of a counter runs at source/2^(k+1)
  logic [MAIN_CNT_W-1:0] main_cnt_q, main_cnt_d;
  logic [SUB_CNT_W-1:0] sub_cnt_q, sub_cnt_d;
  logic [2:0] nf_cnt_q, nf_cnt_d;
  logic sys_rise, nf_tick;

  assign sys_rise = sys_sub_sel ? sub_rise : main_rise;
  assign nf_tick = sys_rise && (nf_cnt_q == NF_CNT_LAST);

  always_comb begin
    main_cnt_d = main_cnt_q + MAIN_CNT_W'(main_rise);
    sub_cnt_d = sub_cnt_q + SUB_CNT_W'(sub_rise);
    nf_cnt_d = nf_cnt_q + 3'(sys_rise);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      main_cnt_q <= '0;
      sub_cnt_q <= '0;
      nf_cnt_q <= 3'h0;
    end else begin
      main_cnt_q <= main_cnt_d;
      sub_cnt_q <= sub_cnt_d;
      nf_cnt_q <= nf_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection and gating
  logic [2:0] lcd_code, tmr_code;
  logic [3:0] lcd_bit;
  logic lcd_d_clk, tmr_d_clk, mout_d_clk, sout_d_clk;
  logic lcd_clk_q, tmr_clk_q, mout_q, sout_q;

  always_comb begin
    lcd_code = (lcd_div > LCD_DIV_MAX) ? LCD_DIV_MAX : lcd_div;
    lcd_bit = LCD_DIV_BASE_BIT + {1'b0, lcd_code};
    tmr_code = (tmr_div > TMR_DIV_MAX) ? TMR_DIV_MAX : tmr_div;
    if (lcd_src_sub) begin
      lcd_d_clk = lcd_en & sub_lvl;
    end else begin
      lcd_d_clk = lcd_en & main_cnt_q[lcd_bit];
    end
    if (tmr_code == 3'h0) begin
      tmr_d_clk = tmr_en & sub_lvl;
    end else begin
      tmr_d_clk = tmr_en & sub_cnt_q[tmr_code - 3'h1];
    end
    // Reserved main output code falls back to 1/4
    if (out_div == 2'h0) begin
      mout_d_clk = mout_en & main_lvl;
    end else if (out_div == 2'h1) begin
      mout_d_clk = mout_en & main_cnt_q[0];
    end else begin
      mout_d_clk = mout_en & main_cnt_q[1];
    end
    sout_d_clk = sout_en & sub_lvl;
  end

  // Enables gate the running clock with no phase alignment, so runts can occur
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lcd_clk_q <= 1'b0;
      tmr_clk_q <= 1'b0;
      mout_q <= 1'b0;
      sout_q <= 1'b0;
    end else begin
      lcd_clk_q <= lcd_d_clk;
      tmr_clk_q <= tmr_d_clk;
      mout_q <= mout_d_clk;
      sout_q <= sout_d_clk;
    end
  end

  // Undivided main clock is resampled, so duty jitters by one CLK period
  assign LCD_CLOCK = lcd_clk_q;
  assign TIMER_CLOCK = tmr_clk_q;
  assign MAIN_CLK_OUT = mout_q;
  assign SUB_CLK_OUT = sout_q;

  ////////////////////////////////////////////////////////////////////////////
  // Noise filters toward the core
  logic rst_filt, nmi_filt, core_rst_n_q, core_nmi_q;

  pcg_noise_filter u_rst_filter (
    .clk(CLK),
    .rst_n(RST_N),
    .sample_tick(nf_tick),
    .enable(nf_q[NF_RST_BIT]),
    .din(~rst_sync_q[1]),
    .dout(rst_filt)
  );

  pcg_noise_filter u_nmi_filter (
    .clk(CLK),
    .rst_n(RST_N),
    .sample_tick(nf_tick),
    .enable(nf_q[NF_NMI_BIT]),
    .din(nmi_sync_q[1]),
    .dout(nmi_filt)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      core_rst_n_q <= 1'b1;
      core_nmi_q <= 1'b0;
    end else begin
      core_rst_n_q <= ~rst_filt;
      core_nmi_q <= nmi_filt;
    end
  end

  assign CORE_RESET_N = core_rst_n_q;
  assign CORE_NMI = core_nmi_q;

  ////////////////////////////////////////////////////////////////////////////
  reset_values_a: assert property (@(posedge CLK) !RST_N |=> nf_q == NF_RESET && lcd_q == LCD_RESET)
    else $error("register reset values wrong");
  lcd_block_a: assert property (@(posedge CLK) disable iff (!RST_N) !lcd_en |=> !LCD_CLOCK)
    else $error("LCD clock not blocked");
  lcd_sub_a: assert property (@(posedge CLK) disable iff (!RST_N)
    lcd_en && lcd_src_sub |=> LCD_CLOCK == $past(sub_lvl))
    else $error("LCD clock not sub oscillator");
  lcd_div32_a: assert property (@(posedge CLK) disable iff (!RST_N)
    lcd_en && !lcd_src_sub && lcd_div == 3'h0 |=> LCD_CLOCK == $past(main_cnt_q[4]))
    else $error("LCD 1/32 divide wrong");
  lcd_reserved_a: assert property (@(posedge CLK) disable iff (!RST_N)
    lcd_en && !lcd_src_sub && lcd_div > 3'h4 |=> LCD_CLOCK == $past(main_cnt_q[8]))
    else $error("reserved LCD code not 1/512");
  timer_div_a: assert property (@(posedge CLK) disable iff (!RST_N)
    tmr_en && tmr_div == 3'h5 |=> TIMER_CLOCK == $past(sub_cnt_q[4]))
    else $error("timer 1/32 divide wrong");
  timer_block_a: assert property (@(posedge CLK) disable iff (!RST_N) !tmr_en |=> !TIMER_CLOCK)
    else $error("timer clock not blocked");
  main_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
    mout_en && out_div == 2'h2 |=> MAIN_CLK_OUT == $past(main_cnt_q[1]))
    else $error("main output divide wrong");
  sub_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ##1 SUB_CLK_OUT == $past(sout_en && sub_lvl))
    else $error("sub output wrong");
  filter_tick_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !sys_sub_sel && main_rise && nf_cnt_q == 3'h7 |-> nf_tick)
    else $error("filter tick missing");
  lcd_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    PSEL && PENABLE && PWRITE && PADDR == ADDR_LCD |=> lcd_q == ($past(PWDATA[7:0]) & LCD_MASK))
    else $error("LCD register write lost");
  unmapped_err_a: assert property (@(posedge CLK) disable iff (!RST_N) PSEL && PENABLE && !hit |-> PSLVERR)
    else $error("unmapped access without error");

  lcd_main_c: cover property (@(posedge CLK) disable iff (!RST_N) lcd_en && !lcd_src_sub && $rose(LCD_CLOCK));
  core_reset_c: cover property (@(posedge CLK) disable iff (!RST_N) $fell(CORE_RESET_N));
  core_nmi_c: cover property (@(posedge CLK) disable iff (!RST_N) nf_q[NF_NMI_BIT] && $rose(CORE_NMI));
  main_out_c: cover property (@(posedge CLK) disable iff (!RST_N) $rose(MAIN_CLK_OUT));

endmodule

// File: verif/pcg_osc_model.sv
`timescale 1ns/1ps
// Both oscillators run free, as crystals do; stepped on the system clock
// so every divided period is an exact count of system cycles
module pcg_osc_model #(
  parameter int MAIN_HALF = 2,
  parameter int SUB_HALF = 6
) (
  input wire logic clk,
  output logic main_osc,
  output logic sub_osc
);
  int main_cnt = 0;
  int sub_cnt = 0;
  initial begin
    main_osc = 1'b0;
    sub_osc = 1'b0;
  end
  always @(posedge clk) begin
    main_cnt <= (main_cnt == MAIN_HALF - 1) ? 0 : main_cnt + 1;
    sub_cnt <= (sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
    if (main_cnt == MAIN_HALF - 1) main_osc <= ~main_osc;
    if (sub_cnt == SUB_HALF - 1) sub_osc <= ~sub_osc;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Shared pins stay plain port pins, held low, until software routes the clock
module pcg_pin_model (
  input wire logic main_sel,
  input wire logic sub_sel,
  input wire logic main_clk,
  input wire logic sub_clk,
  output logic main_pin,
  output logic sub_pin
);
  assign main_pin = main_sel ? main_clk : 1'b0;
  assign sub_pin = sub_sel ? sub_clk : 1'b0;
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pcg_pkg::*;
  localparam int MAIN_P = 4;
  localparam int SUB_P = 12;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic reset_req_n = 1'b1;
  logic wdt_nmi_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, main_osc, sub_osc, lcd_clock, timer_clock;
  logic main_clk_out, sub_clk_out, core_reset_n, core_nmi, err;
  logic [31:0] d;
  logic [31:0] w;
  logic main_pin_sel = 1'b0;
  logic sub_pin_sel = 1'b0;
  logic main_pin, sub_pin;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  int k;
  logic [31:0] ra [5] = '{ADDR_SYS_SRC, ADDR_NF, ADDR_LCD, ADDR_OUT, ADDR_TMR};
  logic [7:0] rm [5] = '{SYS_SRC_MASK, NF_MASK, LCD_MASK, OUT_MASK, TMR_MASK};
  logic [7:0] rr [5] = '{SYS_SRC_RESET, NF_RESET, LCD_RESET, OUT_RESET, TMR_RESET};

  pcg_osc_model #(.MAIN_HALF(MAIN_P / 2), .SUB_HALF(SUB_P / 2)) osc (.clk(clk), .main_osc(main_osc),
    .sub_osc(sub_osc));
  pcg_top uut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MAIN_OSC_CLK(main_osc),
    .SUB_OSC_CLK(sub_osc), .RESET_REQ_N(reset_req_n), .WDT_NMI_REQ(wdt_nmi_req), .LCD_CLOCK(lcd_clock),
    .TIMER_CLOCK(timer_clock), .MAIN_CLK_OUT(main_clk_out), .SUB_CLK_OUT(sub_clk_out),
    .CORE_RESET_N(core_reset_n), .CORE_NMI(core_nmi));
  pcg_pin_model pins (.main_sel(main_pin_sel), .sub_sel(sub_pin_sel), .main_clk(main_clk_out),
    .sub_clk(sub_clk_out), .main_pin(main_pin), .sub_pin(sub_pin));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Longest run is the slowest LCD ratio measured three times over, for codes 4 to 7
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reset_dut();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return lcd_clock;
      1: return timer_clock;
      2: return main_pin;
      default: return sub_pin;
    endcase
  endfunction

  // Expected period in system cycles for a divider code
  function automatic int per(input int s, input int c);
    case (s)
      0: return MAIN_P * (32 << ((c > 4) ? 4 : c));
      1: return SUB_P * (1 << ((c > 5) ? 5 : c));
      default: return MAIN_P * (1 << ((c > 2) ? 2 : c));
    endcase
  endfunction

  function automatic logic act(input int w);
    return (w == 0) ? ~core_reset_n : core_nmi;
  endfunction

  // Counts sampled cycles up to the next rising edge, or lim plus one if none
  task automatic rise(input int s, input int lim, output int cnt);
    logic p;
    logic c;
    cnt = 0;
    @(negedge clk);
    p = sig(s);
    forever begin
      @(negedge clk);
      cnt++;
      c = sig(s);
      if ((c === 1'b1 && p === 1'b0) || cnt > lim) break;
      p = c;
    end
  endtask

  // First edge after a setting change may be a runt, so it is skipped
  task automatic meas(input int s, input int per);
    rise(s, 5000, n);
    rise(s, 5000, n);
    rise(s, 5000, n);
    chk("clock period", per, n + 1);
  endtask

  task automatic filt(input int w, input int len, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    if (w == 0) reset_req_n <= 1'b0;
    else wdt_nmi_req <= 1'b1;
    repeat (len) begin
      @(negedge clk);
      seen = seen | act(w);
      @(posedge clk);
    end
    reset_req_n <= 1'b1;
    wdt_nmi_req <= 1'b0;
    repeat (400) begin
      @(negedge clk);
      seen = seen | act(w);
    end
    chk("filter passed", {31'h0, exp}, {31'h0, seen});
    chk("filter idle", 32'h0, {31'h0, act(w)});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(33));
    reset_dut();
    main_pin_sel <= 1'b1;
    sub_pin_sel <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0, d);
      chk("reset value", {24'h0, rr[i]}, d);
    end
    for (int s = 0; s < 4; s++) begin
      rise(s, 450, n);
      chk("disabled clock", 451, n);
    end
    apb(1'b1, 32'h0001_4184, 32'h0000_00FF, d);
    apb(1'b0, 32'h0001_4184, 32'h0, d);
    chk("unmapped read", 32'h0, d);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int i = 0; i < 12; i++) begin
      k = $urandom % 5;
      w = $urandom;
      apb(1'b1, ra[k], w, d);
      apb(1'b0, ra[k], 32'h0, d);
      chk("read back", w & {24'h0, rm[k]}, d);
      chk("mapped error", 32'h0, {31'h0, err});
    end
    reset_dut();
    apb(1'b1, ADDR_LCD, 32'h0000_0013, d);
    meas(0, SUB_P);
    // Display assumed off; one LCD clock passes before the enable is cleared
    rise(0, 5000, n);
    apb(1'b1, ADDR_LCD, 32'h0000_0012, d);
    rise(0, 100, n);
    chk("disabled LCD clock", 101, n);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ADDR_LCD, (c << 2) | 1, d);
      meas(0, per(0, c));
    end
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ADDR_TMR, (c << 1) | 1, d);
      meas(1, per(1, c));
    end
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_OUT, (c << 2) | 3, d);
      meas(2, per(2, c));
    end
    meas(3, SUB_P);
    apb(1'b1, ADDR_OUT, 32'h0000_000C, d);
    for (int s = 2; s < 4; s++) begin
      rise(s, 100, n);
      chk("disabled output", 101, n);
    end
    filt(0, 16, 1'b0);
    filt(0, 80, 1'b1);
    apb(1'b1, ADDR_NF, 32'h0000_0001, d);
    filt(0, 2, 1'b1);
    filt(1, 16, 1'b0);
    filt(1, 80, 1'b1);
    apb(1'b1, ADDR_SYS_SRC, 32'h0000_0001, d);
    filt(1, 80, 1'b0);
    filt(1, 240, 1'b1);
    apb(1'b1, ADDR_NF, 32'h0000_0002, d);
    filt(1, 2, 1'b1);
    close_out();
  end
endmodule
